// ### src/sfwp_pkg.sv
// shared constants and types for the serial flash write-protect block
package sfwp_pkg;
  // command codes
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OPC_CONT_PROGRAM = 8'hAD;
  localparam logic [7:0] OPC_FOUR_KB_WIPE = 8'h20;
  localparam logic [7:0] OPC_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OPC_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OPC_CHIP_WIPE = 8'hC7;
  localparam logic [7:0] OPC_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] OPC_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] OPC_ALL_LOCK = 8'h7E;
  localparam logic [7:0] OPC_ALL_UNLOCK = 8'h98;
  localparam logic [7:0] OPC_SCHEME_SELECT = 8'h68;
  localparam logic [7:0] OPC_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OPC_POWER_WAKE = 8'hAB;
  localparam logic [7:0] OPC_OTP_ENTER = 8'hB1;
  localparam logic [7:0] OPC_OTP_EXIT = 8'hC1;
  localparam logic [7:0] OPC_SECURITY_READ = 8'h2B;
  localparam logic [7:0] OPC_SECURITY_WRITE = 8'h2F;
  // frame lengths in bits
  localparam logic [11:0] LEN_OPCODE = 12'h008;
  localparam logic [11:0] LEN_STATUS = 12'h010;
  localparam logic [11:0] LEN_CONFIG = 12'h018;
  localparam logic [11:0] LEN_ADDRESS = 12'h020;
  // array geometry
  localparam int NUM_BLOCKS = 128;
  localparam int BLOCK_LSB = 16;
  localparam logic [8:0] OTP_FACTORY_END = 9'h010;
  // status, config and security byte fields
  localparam int ST_LATCH = 1;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_QUAD = 6;
  localparam int ST_LOCK = 7;
  localparam int CF_ORIGIN = 3;
  localparam int SEC_FACTORY = 0;
  localparam int SEC_CUSTOMER = 1;
  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SECURITY = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_BLOCK_SEL = 8'h0C;
  localparam logic [7:0] REG_BLOCK_STAT = 8'h10;
  localparam logic [7:0] REG_LAST_CMD = 8'h14;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  typedef enum logic [1:0] {SFWP_STANDBY, SFWP_SHIFT, SFWP_IGNORE} sfwp_state_e;
  typedef enum logic [2:0] {SFWP_OP_PROGRAM, SFWP_OP_WIPE_4K, SFWP_OP_WIPE_32K,
    SFWP_OP_WIPE_64K, SFWP_OP_WIPE_CHIP} sfwp_op_e;
endpackage

// ### src/sfwp_top.sv
// write-protect and secured one-time area logic of a serial flash
// What this block does
// - after power-up the command machine sits in standby, nothing in progress
// - a command acts only if its length is whole bytes on a boundary
// - data-changing commands are refused while the write latch is clear
// - latch clears at power-up and after write-disable or status-write
// - latch clears after program, erase, and single or all-block lock/unlock
// - in deep power-down only the wake/signature command is obeyed
// - origin 0, level n of 1..7 protects top 2^(n-1) blocks ending at 127
// - origin 1, level n of 1..7 protects lowest 2^(n-1) blocks from 0
// - levels 8 to 15 protect all 128 blocks
// - chip erase only when all four level bits are zero
// - guard pin low with status lock freezes level and lock bits
// - hardware guard is off in four-line mode
// - scheme select enables per-block lock and unlock commands
// - in per-block mode all-lock and all-unlock act on every block
// - 4K-bit one-time area: 128-bit serial number then 3968 customer bits
// - security bit 0 shows the factory lock
// - security write with bit 1 set records the customer lock
// - once locked, the lock and one-time contents never change
// - main array refused while one-time mode is active
// - pause pin suspends the link without deselecting
// - mutating commands must end exactly on a byte boundary or are rejected
// - pause is disabled in four-line mode
//
// Our own choices: register access over AHB-Lite and the register addresses.
module sfwp_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic data_line0,
  input wire logic data_line1_i,
  output logic data_line1_o,
  output logic data_line1_oe,
  input wire logic write_guard_n,
  input wire logic pause_n,
  output logic array_op_valid,
  output sfwp_pkg::sfwp_op_e array_op_kind,
  output logic [23:0] array_op_addr,
  output logic array_op_otp
);
  import sfwp_pkg::*;

  // two-stage synchronisers for all pins except the unused data_line1_i
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic cs_q_reg;
  logic sclk_q_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // clock bit resets low like its idle pin, so no false edge follows reset
      pin_meta_reg <= 5'h17;
      pin_sync_reg <= 5'h17;
      cs_q_reg <= 1'b1;
      sclk_q_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {chip_select_n, serial_clock, data_line0, write_guard_n, pause_n};
      pin_sync_reg <= pin_meta_reg;
      cs_q_reg <= pin_sync_reg[4];
      sclk_q_reg <= pin_sync_reg[3];
    end
  end
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic guard_n_s;
  logic pause_n_s;
  assign cs_n_s = pin_sync_reg[4];
  assign sclk_s = pin_sync_reg[3];
  assign din_s = pin_sync_reg[2];
  assign guard_n_s = pin_sync_reg[1];
  assign pause_n_s = pin_sync_reg[0];

  // protection state
  logic latch_reg;
  logic [3:0] level_reg;
  logic origin_reg;
  logic status_lock_reg;
  logic quad_reg;
  logic power_down_reg;
  logic otp_mode_reg;
  logic per_block_reg;
  logic factory_lock_reg;
  logic customer_lock_reg;
  logic [NUM_BLOCKS-1:0] block_lock_reg;
  logic [31:0] control_reg;
  logic [6:0] block_sel_reg;
  logic [7:0] last_opcode_reg;
  logic last_ok_reg;
  logic last_bad_reg;

  // pause holds the link only outside four-line mode
  logic paused;
  assign paused = !pause_n_s && !quad_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s && !sclk_q_reg && !cs_n_s && !paused;
  assign sclk_fall = !sclk_s && sclk_q_reg && !cs_n_s && !paused;
  assign cs_fall = !cs_n_s && cs_q_reg;
  assign cs_rise = cs_n_s && !cs_q_reg;

  // frame capture
  sfwp_state_e state_reg;
  logic [11:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] status_in_reg;
  logic [7:0] config_in_reg;
  logic [23:0] addr_reg;
  logic [7:0] shift_next;
  assign shift_next = {shift_reg[6:0], din_s};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= SFWP_STANDBY;
      bit_cnt_reg <= 12'h000;
      shift_reg <= 8'h00;
      opcode_reg <= 8'h00;
      status_in_reg <= 8'h00;
      config_in_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
    end
    else if (cs_fall)
    begin
      state_reg <= control_reg[0] ? SFWP_SHIFT : SFWP_IGNORE;
      bit_cnt_reg <= 12'h000;
    end
    else if (cs_rise)
      state_reg <= SFWP_STANDBY;
    else if (sclk_rise && state_reg == SFWP_SHIFT)
    begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != 12'hFFF)
        bit_cnt_reg <= bit_cnt_reg + 12'h001;
      if (bit_cnt_reg + 12'h001 == LEN_OPCODE)
        opcode_reg <= shift_next;
      if (bit_cnt_reg + 12'h001 == LEN_STATUS)
        status_in_reg <= shift_next;
      if (bit_cnt_reg + 12'h001 == LEN_CONFIG)
        config_in_reg <= shift_next;
      if (bit_cnt_reg >= LEN_OPCODE && bit_cnt_reg < LEN_ADDRESS)
        addr_reg <= {addr_reg[22:0], din_s};
    end
  end

  function automatic logic level_covers(input logic [6:0] blk, input logic [3:0] lvl,
    input logic org);
    logic [7:0] span;
    span = 8'h01 << (lvl[2:0] - 3'd1);
    if (lvl == 4'h0)
      level_covers = 1'b0;
    else if (lvl[3])
      level_covers = 1'b1;
    else if (org)
      level_covers = {1'b0, blk} < span;
    else
      level_covers = {1'b0, blk} >= 8'd128 - span;
  endfunction

  function automatic logic is_protected(input logic [6:0] blk, input logic [3:0] lvl,
    input logic org, input logic per_blk, input logic [NUM_BLOCKS-1:0] locks);
    is_protected = per_blk ? locks[blk] : level_covers(blk, lvl, org);
  endfunction

  // command decision at deselect
  logic frame_end;
  logic whole_bytes;
  logic has_addr;
  logic [6:0] target_blk;
  logic target_prot;
  logic otp_locked;
  logic guard_on;
  assign frame_end = cs_rise && state_reg == SFWP_SHIFT;
  assign whole_bytes = bit_cnt_reg != 12'h000 && bit_cnt_reg[2:0] == 3'd0;
  assign has_addr = bit_cnt_reg >= LEN_ADDRESS;
  assign target_blk = addr_reg[BLOCK_LSB+6:BLOCK_LSB];
  assign target_prot = is_protected(target_blk, level_reg, origin_reg, per_block_reg,
    block_lock_reg);
  assign otp_locked = factory_lock_reg || customer_lock_reg;
  assign guard_on = status_lock_reg && !guard_n_s && !quad_reg;

  logic ok;
  logic do_write_enable_cmd;
  logic do_write_disable_cmd;
  logic do_status_write_cmd;
  logic do_prog;
  logic do_wipe;
  sfwp_op_e wipe_kind;
  logic do_lock_one;
  logic do_lock_all;
  logic do_scheme;
  logic do_down;
  logic do_wake;
  logic do_otp_in;
  logic do_otp_out;
  logic do_secw;
  logic clear_latch;
  always_comb
  begin
    ok = frame_end && whole_bytes;
    do_write_enable_cmd = 1'b0;
    do_write_disable_cmd = 1'b0;
    do_status_write_cmd = 1'b0;
    do_prog = 1'b0;
    do_wipe = 1'b0;
    wipe_kind = SFWP_OP_WIPE_4K;
    do_lock_one = 1'b0;
    do_lock_all = 1'b0;
    do_scheme = 1'b0;
    do_down = 1'b0;
    do_wake = 1'b0;
    do_otp_in = 1'b0;
    do_otp_out = 1'b0;
    do_secw = 1'b0;
    clear_latch = 1'b0;
    if (ok && power_down_reg)
      do_wake = opcode_reg == OPC_POWER_WAKE;
    else if (ok)
    begin
      case (opcode_reg)
        OPC_WRITE_ENABLE: do_write_enable_cmd = 1'b1;
        OPC_WRITE_DISABLE: do_write_disable_cmd = 1'b1;
        OPC_POWER_DOWN: do_down = 1'b1;
        OPC_OTP_ENTER: do_otp_in = 1'b1;
        OPC_OTP_EXIT: do_otp_out = 1'b1;
        OPC_STATUS_WRITE: do_status_write_cmd = latch_reg && bit_cnt_reg >= LEN_STATUS && !guard_on;
        OPC_PAGE_PROGRAM, OPC_QUAD_PAGE_PROGRAM, OPC_CONT_PROGRAM:
          do_prog = latch_reg && has_addr &&
            (otp_mode_reg ? !otp_locked : !target_prot);
        OPC_FOUR_KB_WIPE, OPC_HALF_BLOCK_WIPE, OPC_BLOCK_WIPE:
        begin
          do_wipe = latch_reg && has_addr && !otp_mode_reg && !target_prot;
          wipe_kind = opcode_reg == OPC_FOUR_KB_WIPE ? SFWP_OP_WIPE_4K :
            opcode_reg == OPC_HALF_BLOCK_WIPE ? SFWP_OP_WIPE_32K : SFWP_OP_WIPE_64K;
        end
        OPC_CHIP_WIPE:
        begin
          do_wipe = latch_reg && !otp_mode_reg && level_reg == 4'h0;
          wipe_kind = SFWP_OP_WIPE_CHIP;
        end
        OPC_SINGLE_LOCK, OPC_SINGLE_UNLOCK:
          do_lock_one = latch_reg && per_block_reg && has_addr;
        OPC_ALL_LOCK, OPC_ALL_UNLOCK: do_lock_all = latch_reg && per_block_reg;
        OPC_SCHEME_SELECT: do_scheme = latch_reg;
        OPC_SECURITY_WRITE: do_secw = latch_reg;
        default: do_write_enable_cmd = 1'b0;
      endcase
    end
    // a status write, program, erase, lock or unlock command spends the latch even when the target was protected
    if (ok && !power_down_reg && latch_reg)
    begin
      case (opcode_reg)
        OPC_STATUS_WRITE, OPC_PAGE_PROGRAM, OPC_QUAD_PAGE_PROGRAM, OPC_CONT_PROGRAM,
        OPC_FOUR_KB_WIPE, OPC_HALF_BLOCK_WIPE, OPC_BLOCK_WIPE, OPC_CHIP_WIPE,
        OPC_SINGLE_LOCK, OPC_SINGLE_UNLOCK, OPC_ALL_LOCK, OPC_ALL_UNLOCK:
          clear_latch = 1'b1;
        default: clear_latch = 1'b0;
      endcase
    end
    if (do_write_disable_cmd)
      clear_latch = 1'b1;
  end

  // write latch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_reg <= 1'b0;
    else if (do_write_enable_cmd)
      latch_reg <= 1'b1;
    else if (clear_latch)
      latch_reg <= 1'b0;
  end

  // status bits, power and mode flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level_reg <= 4'h0;
      origin_reg <= 1'b0;
      status_lock_reg <= 1'b0;
      quad_reg <= 1'b0;
      power_down_reg <= 1'b0;
      otp_mode_reg <= 1'b0;
      per_block_reg <= 1'b0;
    end
    else
    begin
      if (do_status_write_cmd)
      begin
        level_reg <= status_in_reg[ST_LEVEL_LSB+3:ST_LEVEL_LSB];
        status_lock_reg <= status_in_reg[ST_LOCK];
        quad_reg <= status_in_reg[ST_QUAD];
        if (bit_cnt_reg >= LEN_CONFIG)
          origin_reg <= config_in_reg[CF_ORIGIN];
      end
      if (do_down)
        power_down_reg <= 1'b1;
      else if (do_wake)
        power_down_reg <= 1'b0;
      if (do_otp_in)
        otp_mode_reg <= 1'b1;
      else if (do_otp_out)
        otp_mode_reg <= 1'b0;
      if (do_scheme)
        per_block_reg <= 1'b1;
    end
  end

  // per-block locks; after reset every block comes up locked in per-block mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      block_lock_reg <= {NUM_BLOCKS{1'b1}};
    else if (do_lock_all)
      block_lock_reg <= {NUM_BLOCKS{opcode_reg == OPC_ALL_LOCK}};
    else if (do_lock_one)
      block_lock_reg[target_blk] <= opcode_reg == OPC_SINGLE_LOCK;
  end

  // one-time area locks never clear once set
  logic bus_wr;
  logic [7:0] bus_addr_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      factory_lock_reg <= 1'b0;
      customer_lock_reg <= 1'b0;
    end
    else
    begin
      if (bus_wr && bus_addr_reg == REG_SECURITY && hwdata[SEC_FACTORY])
        factory_lock_reg <= 1'b1;
      if (do_secw && bit_cnt_reg >= LEN_STATUS && status_in_reg[SEC_CUSTOMER])
        customer_lock_reg <= 1'b1;
    end
  end

  // array operations handed to the program/erase engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      array_op_valid <= 1'b0;
      array_op_kind <= SFWP_OP_PROGRAM;
      array_op_addr <= 24'h00_0000;
      array_op_otp <= 1'b0;
    end
    else
    begin
      array_op_valid <= do_prog || do_wipe;
      if (do_prog || do_wipe)
      begin
        array_op_kind <= do_prog ? SFWP_OP_PROGRAM : wipe_kind;
        // one-time area is 512 bytes: serial number then customer bytes
        array_op_addr <= otp_mode_reg ? {15'h0000, addr_reg[8:0]} : addr_reg;
        array_op_otp <= otp_mode_reg;
      end
    end
  end

  // status and security read-back on the second data line
  logic [7:0] out_shift_reg;
  logic out_active_reg;
  logic [7:0] status_byte;
  assign status_byte = {status_lock_reg, quad_reg, level_reg, latch_reg, 1'b0};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_shift_reg <= 8'h00;
      out_active_reg <= 1'b0;
      data_line1_o <= 1'b0;
      data_line1_oe <= 1'b0;
    end
    else
    begin
      if (cs_n_s)
        out_active_reg <= 1'b0;
      else if (sclk_rise && state_reg == SFWP_SHIFT && bit_cnt_reg + 12'h001 == LEN_OPCODE
        && !power_down_reg)
      begin
        out_active_reg <= shift_next == OPC_STATUS_READ || shift_next == OPC_SECURITY_READ;
        out_shift_reg <= shift_next == OPC_STATUS_READ ? status_byte :
          {6'h00, customer_lock_reg, factory_lock_reg};
      end
      else if (sclk_fall && out_active_reg)
      begin
        data_line1_o <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], out_shift_reg[7]};
      end
      // the line floats while paused so the host may share it
      data_line1_oe <= out_active_reg && !cs_n_s && !paused;
    end
  end

  // ahb-lite slave, zero wait states
  logic bus_rd;
  logic bus_wr_pend_reg;
  assign bus_rd = hsel && hready && htrans[1] && !hwrite;
  assign bus_wr = bus_wr_pend_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_wr_pend_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      bus_wr_pend_reg <= hsel && htrans[1] && hwrite && hsize == 3'd2;
      bus_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control_reg <= CONTROL_RESET;
      block_sel_reg <= 7'h00;
    end
    else if (bus_wr && bus_addr_reg == REG_CONTROL)
      control_reg <= {31'h0000_0000, hwdata[0]};
    else if (bus_wr && bus_addr_reg == REG_BLOCK_SEL)
      block_sel_reg <= hwdata[6:0];
  end

  // last decided command, for software to audit byte-boundary refusals
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_opcode_reg <= 8'h00;
      last_ok_reg <= 1'b0;
      last_bad_reg <= 1'b0;
    end
    else if (frame_end)
    begin
      last_opcode_reg <= opcode_reg;
      last_ok_reg <= whole_bytes;
      last_bad_reg <= !whole_bytes;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (bus_rd)
    begin
      case (haddr[7:0])
        REG_STATUS: hrdata <= {20'h0_0000, per_block_reg, otp_mode_reg, power_down_reg,
          origin_reg, status_byte};
        REG_SECURITY: hrdata <= {30'h0000_0000, customer_lock_reg, factory_lock_reg};
        REG_CONTROL: hrdata <= control_reg;
        REG_BLOCK_SEL: hrdata <= {25'h000_0000, block_sel_reg};
        REG_BLOCK_STAT: hrdata <= {30'h0000_0000, block_lock_reg[block_sel_reg],
          is_protected(block_sel_reg, level_reg, origin_reg, per_block_reg, block_lock_reg)};
        REG_LAST_CMD: hrdata <= {22'h00_0000, last_bad_reg, last_ok_reg, last_opcode_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### tb/sfwp_top_props.sv
// port assertions for the write-protect block
module sfwp_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic chip_select_n,
  input wire logic data_line1_oe,
  input wire logic array_op_valid,
  input wire sfwp_pkg::sfwp_op_e array_op_kind,
  input wire logic [23:0] array_op_addr,
  input wire logic array_op_otp
);
  timeunit 1ns;
  timeprecision 1ns;
  import sfwp_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_RESET_IDLE: assert property (!$past(hresetn) |-> !array_op_valid)
    else $error("op right after reset");
  AST_OP_PULSE: assert property (array_op_valid |=> !array_op_valid)
    else $error("op pulse too long");
  AST_OP_AT_DESELECT: assert property (array_op_valid |-> chip_select_n)
    else $error("op while selected");
  AST_OP_AFTER_FRAME: assert property (array_op_valid |-> !$past(chip_select_n, 8))
    else $error("op without a frame");
  AST_OP_HOLD: assert property (!array_op_valid |-> $stable(array_op_kind) &&
    $stable(array_op_addr) && $stable(array_op_otp))
    else $error("op fields moved without op");
  AST_OTP_RANGE: assert property (array_op_valid && array_op_otp |->
    array_op_addr[23:9] == 15'h0000)
    else $error("one-time offset too large");
  AST_OTP_PROGRAM: assert property (array_op_valid && array_op_otp |->
    array_op_kind == SFWP_OP_PROGRAM)
    else $error("wipe in one-time area");
  AST_LINE1_QUIET: assert property (chip_select_n [*8] |-> !data_line1_oe)
    else $error("line 1 driven while deselected");
  cover property (array_op_valid && array_op_otp);
  cover property (array_op_valid && array_op_kind == SFWP_OP_WIPE_CHIP);
  cover property (array_op_valid && array_op_kind == SFWP_OP_WIPE_32K);
endmodule
bind sfwp_top sfwp_chk u_chk
(
  .hclk, .hresetn, .chip_select_n, .data_line1_oe, .array_op_valid, .array_op_kind,
  .array_op_addr, .array_op_otp
);

// ### tb/sfwp_spi_host.sv
// spi host model that shifts command frames into the block
module sfwp_spi_host
(
  input wire logic hclk,
  output logic chip_select_n,
  output logic serial_clock,
  output logic data_line0
);
  timeunit 1ns;
  timeprecision 1ns;
  int half = 4;
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    data_line0 = 1'b0;
  end
  // mode 0, msb first; clock stands low between frames
  task automatic frame(input int nbits, input logic [47:0] d);
    @(posedge hclk);
    chip_select_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      data_line0 <= d[i];
      repeat (half) @(posedge hclk);
      serial_clock <= 1'b1;
      repeat (half) @(posedge hclk);
      serial_clock <= 1'b0;
    end
    repeat (half) @(posedge hclk);
    chip_select_n <= 1'b1;
    // released line must not keep the last bit
    data_line0 <= ~data_line0;
    repeat (2 * half) @(posedge hclk);
  endtask
endmodule

// ### tb/sfwp_top_bench.sv
// self-checking bench of the write-protect block
module sfwp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sfwp_pkg::*;
  logic hclk, hreadyout, hresp, data_line1_o, data_line1_oe, array_op_valid, array_op_otp;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, write_guard_n = 1'b1, otp_seen;
  logic chip_select_n, serial_clock, data_line0;
  logic pause_n = 1'b1;
  logic [7:0] rx;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, v;
  logic [23:0] array_op_addr, addr_seen;
  sfwp_op_e array_op_kind, kind_seen;
  int fail_count, comparisons, ops, ops_seen;
  logic [7:0] opc [6] = '{OPC_PAGE_PROGRAM, OPC_QUAD_PAGE_PROGRAM, OPC_CONT_PROGRAM,
    OPC_FOUR_KB_WIPE, OPC_HALF_BLOCK_WIPE, OPC_BLOCK_WIPE};
  sfwp_op_e knd [6] = '{SFWP_OP_PROGRAM, SFWP_OP_PROGRAM, SFWP_OP_PROGRAM,
    SFWP_OP_WIPE_4K, SFWP_OP_WIPE_32K, SFWP_OP_WIPE_64K};
  sfwp_top uut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chip_select_n, .serial_clock,
    .data_line0, .data_line1_i(1'b1), .data_line1_o, .data_line1_oe, .write_guard_n,
    .pause_n, .array_op_valid, .array_op_kind, .array_op_addr, .array_op_otp
  );
  sfwp_spi_host host
  (
    .hclk, .chip_select_n, .serial_clock, .data_line0
  );
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (array_op_valid === 1'b1)
    begin
      ops <= ops + 1;
      kind_seen <= array_op_kind;
      addr_seen <= array_op_addr;
      otp_seen <= array_op_otp;
    end
  // read-back bits as the host would take them at its rising clock edges
  always @(posedge serial_clock)
    if (data_line1_oe === 1'b1)
      rx <= {rx[6:0], data_line1_o};
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, v);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [11:0] m,
    input logic [11:0] e);
    ahb(1'b0, a, 32'h0000_0000, v);
    check(nm, 32'({hresp, v[11:0] & m}), 32'(e));
  endtask
  task automatic op_chk(input int n);
    check("ops", 32'(ops - ops_seen), 32'(n));
    ops_seen = ops;
  endtask
  task automatic op8(input logic [7:0] o);
    host.frame(8, 48'(o));
  endtask
  task automatic wen;
    op8(OPC_WRITE_ENABLE);
  endtask
  task automatic wsr(input logic [7:0] s, input logic [7:0] c);
    wen();
    host.frame(24, 48'({OPC_STATUS_WRITE, s, c}));
  endtask
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    int c, e;
    int bl [6];
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk("st", REG_STATUS, 12'hfff, 12'h000);
    rd_chk("ctl", REG_CONTROL, 12'hfff, 12'h001);
    rd_chk("unmapped", 8'h40, 12'hfff, 12'h000);
    host.frame(40, 48'({OPC_PAGE_PROGRAM, 24'h05_0000, 8'ha5}));
    op_chk(0);
    wen();
    rd_chk("latch", REG_STATUS, 12'h002, 12'h002);
    op8(OPC_WRITE_DISABLE);
    rd_chk("latch", REG_STATUS, 12'h002, 12'h000);
    host.frame(9, 48'({OPC_WRITE_ENABLE, 1'b0}));
    rd_chk("latch", REG_STATUS, 12'h002, 12'h000);
    rd_chk("last", REG_LAST_CMD, 12'hfff, 12'h206);
    foreach (opc[k])
    begin
      wen();
      if (knd[k] == SFWP_OP_PROGRAM)
        host.frame(48, {opc[k], 24'h05_0000, 16'h5aa5});
      else
        host.frame(32, 48'({opc[k], 24'h05_0000}));
      op_chk(1);
      check("kind", 32'(kind_seen), 32'(knd[k]));
      check("addr", 32'(addr_seen), 32'h0005_0000);
      rd_chk("latch", REG_STATUS, 12'h002, 12'h000);
    end
    wen();
    op8(OPC_CHIP_WIPE);
    op_chk(1);
    check("kind", 32'(kind_seen), 32'(SFWP_OP_WIPE_CHIP));
    for (int o = 0; o < 2; o++)
      for (int n = 0; n < 10; n++)
      begin
        wsr(8'(n * 4), 8'(o * 8));
        rd_chk("lvl", REG_STATUS, 12'h1fe, 12'(o * 256 + n * 4));
        c = (n > 0 && n < 8) ? 1 << (n - 1) : 1;
        bl = '{0, 127, c - 1, c, 127 - c, 128 - c};
        foreach (bl[k])
        begin
          e = n == 0 ? 0 : (n > 7 ? 1 : (o == 0 ? int'(bl[k] >= 128 - c) : int'(bl[k] < c)));
          wr(REG_BLOCK_SEL, 32'(bl[k]));
          rd_chk("prot", REG_BLOCK_STAT, 12'h001, 12'(e));
        end
      end
    wsr(8'h04, 8'h00);
    wen();
    host.frame(48, {OPC_PAGE_PROGRAM, 24'h7f_0000, 16'h1234});
    op_chk(0);
    wen();
    op8(OPC_CHIP_WIPE);
    op_chk(0);
    wsr(8'hc0, 8'h00);
    write_guard_n <= 1'b0;
    wsr(8'hc8, 8'h00);
    rd_chk("st", REG_STATUS, 12'h0fc, 12'h0c8);
    wsr(8'h88, 8'h00);
    wsr(8'h8c, 8'h00);
    rd_chk("st", REG_STATUS, 12'h0fc, 12'h088);
    host.frame(16, 48'({OPC_STATUS_READ, 8'h00}));
    check("so", 32'(rx), 32'h0000_0088);
    write_guard_n <= 1'b1;
    wsr(8'h00, 8'h00);
    pause_n <= 1'b0;
    wen();
    rd_chk("latch", REG_STATUS, 12'h002, 12'h000);
    pause_n <= 1'b1;
    wsr(8'h40, 8'h00);
    pause_n <= 1'b0;
    wen();
    rd_chk("latch", REG_STATUS, 12'h042, 12'h042);
    pause_n <= 1'b1;
    wsr(8'h00, 8'h00);
    op8(OPC_POWER_DOWN);
    wen();
    rd_chk("st", REG_STATUS, 12'h202, 12'h200);
    op8(OPC_POWER_WAKE);
    rd_chk("st", REG_STATUS, 12'h200, 12'h000);
    op8(OPC_OTP_ENTER);
    rd_chk("st", REG_STATUS, 12'h400, 12'h400);
    wen();
    host.frame(40, 48'({OPC_PAGE_PROGRAM, 24'h00_0020, 8'h11}));
    op_chk(1);
    check("otp", 32'(otp_seen), 32'h0000_0001);
    check("addr", 32'(addr_seen), 32'h0000_0020);
    wen();
    host.frame(32, 48'({OPC_BLOCK_WIPE, 24'h00_0000}));
    op_chk(0);
    op8(OPC_OTP_EXIT);
    wen();
    host.frame(16, 48'({OPC_SECURITY_WRITE, 8'h02}));
    rd_chk("sec", REG_SECURITY, 12'h003, 12'h002);
    op8(OPC_OTP_ENTER);
    wen();
    host.frame(40, 48'({OPC_PAGE_PROGRAM, 24'h00_0020, 8'h11}));
    op_chk(0);
    op8(OPC_OTP_EXIT);
    wr(REG_SECURITY, 32'h0000_0001);
    wr(REG_SECURITY, 32'h0000_0000);
    rd_chk("sec", REG_SECURITY, 12'h003, 12'h003);
    host.frame(16, 48'({OPC_SECURITY_READ, 8'h00}));
    check("so", 32'(rx), 32'h0000_0003);
    wen();
    op8(OPC_SCHEME_SELECT);
    rd_chk("st", REG_STATUS, 12'h800, 12'h800);
    wr(REG_BLOCK_SEL, 32'h0000_0003);
    rd_chk("blk", REG_BLOCK_STAT, 12'h003, 12'h003);
    wen();
    op8(OPC_ALL_UNLOCK);
    rd_chk("blk", REG_BLOCK_STAT, 12'h003, 12'h000);
    wen();
    host.frame(32, 48'({OPC_SINGLE_LOCK, 24'h03_0000}));
    rd_chk("blk", REG_BLOCK_STAT, 12'h003, 12'h003);
    rd_chk("latch", REG_STATUS, 12'h002, 12'h000);
    wen();
    host.frame(32, 48'({OPC_SINGLE_UNLOCK, 24'h03_0000}));
    rd_chk("blk", REG_BLOCK_STAT, 12'h003, 12'h000);
    wen();
    op8(OPC_ALL_LOCK);
    wr(REG_BLOCK_SEL, 32'h0000_0004);
    rd_chk("blk", REG_BLOCK_STAT, 12'h003, 12'h003);
    finish_test();
  end
endmodule
